// ### dcbm_regs.vh
`ifndef DCBM_REGS_VH
`define DCBM_REGS_VH

// Address split of the data cache: 32-byte blocks, 16 sets
`define DCBM_AW            32
`define DCBM_OFS_W         5
`define DCBM_IDX_W         4
`define DCBM_TAG_W         23
`define DCBM_IDX_LO        5
`define DCBM_IDX_HI        8
`define DCBM_TAG_LO        9
`define DCBM_TAG_HI        31
`define DCBM_ENTRIES       16
`define DCBM_MOD_W         7
`define DCBM_MOD_SHIFT     2

// Operation kinds
`define DCBM_OP_COPYBACK   1'b0
`define DCBM_OP_INVALIDATE 1'b1

// APB register byte offsets
`define DCBM_REG_CTRL      12'h000
`define DCBM_REG_NC_BASE   12'h004
`define DCBM_REG_NC_LIMIT  12'h008
`define DCBM_REG_STATUS    12'h00c
`define DCBM_REG_CB_CNT    12'h010
`define DCBM_REG_INV_CNT   12'h014
`define DCBM_PADDR_W       12

// Reset values
`define DCBM_CTRL_RST      1'b1
`define DCBM_NC_BASE_RST   32'hffff_ffff
`define DCBM_NC_LIMIT_RST  32'h0000_0000
`define DCBM_ZERO32        32'h0000_0000
`define DCBM_ONE16         16'h0001

// Status fields
`define DCBM_ST_BUSY       0
`define DCBM_ST_DRAIN      1
`define DCBM_ST_WRITE      2
`define DCBM_ST_LOCKED     3

`endif

// ### dcbm_addr_calc.v
`default_nettype none
`include "dcbm_regs.vh"

// Target address, set index, tag and aperture check of one operation
module dcbm_addr_calc (
  input  wire [`DCBM_AW-1:0]    base_address_operand_in,
  input  wire [`DCBM_MOD_W-1:0] mod_in,
  input  wire [`DCBM_AW-1:0]    nc_base_in,
  input  wire [`DCBM_AW-1:0]    nc_limit_in,
  output wire [`DCBM_AW-1:0]    addr_out,
  output wire [`DCBM_IDX_W-1:0] index_out,
  output wire [`DCBM_TAG_W-1:0] tag_out,
  output wire                   cacheable_out
);

  // Modifier is a signed word count; scaled by four it spans -256..252
  wire [`DCBM_AW-1:0] offset;  // Sign-extended byte offset

  // Two appended zero bits keep the offset a multiple of four by construction
  assign offset = {{(`DCBM_AW-`DCBM_MOD_W-`DCBM_MOD_SHIFT)
                    {mod_in[`DCBM_MOD_W-1]}},
                   mod_in, {`DCBM_MOD_SHIFT{1'b0}}};

  // Byte address of the target block
  assign addr_out = base_address_operand_in + offset;

  assign index_out = addr_out[`DCBM_IDX_HI:`DCBM_IDX_LO];
  assign tag_out   = addr_out[`DCBM_TAG_HI:`DCBM_TAG_LO];

  // Inside [base, limit] the memory is uncached; an empty window if base>limit
  assign cacheable_out = ~((addr_out >= nc_base_in) &&
                           (addr_out <= nc_limit_in));

endmodule

`default_nettype wire

// ### dcbm_tag_store.v
`default_nettype none
`include "dcbm_regs.vh"

// Tag, valid, dirty and lock state of the data cache, one entry per set
module dcbm_tag_store (
  input  wire                   sys_clk_in,
  input  wire                   rst_n_in,
  input  wire [`DCBM_IDX_W-1:0] lk_index_in,
  input  wire [`DCBM_TAG_W-1:0] lk_tag_in,
  output wire                   lk_hit_out,
  output wire                   lk_dirty_out,
  output wire                   lk_locked_out,
  input  wire                   fill_en_in,
  input  wire [`DCBM_IDX_W-1:0] fill_index_in,
  input  wire [`DCBM_TAG_W-1:0] fill_tag_in,
  input  wire                   fill_dirty_in,
  input  wire                   fill_lock_in,
  input  wire                   clr_dirty_in,
  input  wire                   inval_in,
  input  wire [`DCBM_IDX_W-1:0] mt_index_in
);

  reg [`DCBM_ENTRIES-1:0] valid_ff;                 // Block present
  reg [`DCBM_ENTRIES-1:0] dirty_ff;                 // Block modified
  reg [`DCBM_ENTRIES-1:0] lock_ff;                  // Block pinned
  reg [`DCBM_TAG_W-1:0]   tag_ff [0:`DCBM_ENTRIES-1];

  // Lookup: combinational read of the addressed set
  assign lk_hit_out    = valid_ff[lk_index_in] &&
                         (tag_ff[lk_index_in] == lk_tag_in);
  assign lk_dirty_out  = dirty_ff[lk_index_in];
  assign lk_locked_out = lock_ff[lk_index_in];

  genvar i;
  generate
    for (i = 0; i < `DCBM_ENTRIES; i = i + 1) begin : g_ent
      // Maintenance wins over a fill of the same set in the same cycle
      always @(posedge sys_clk_in) begin
        if (!rst_n_in) begin
          valid_ff[i] <= 1'b0;
          dirty_ff[i] <= 1'b0;
          lock_ff[i]  <= 1'b0;
          tag_ff[i]   <= {`DCBM_TAG_W{1'b0}};
        end else if (inval_in && (mt_index_in == i)) begin
          // Lock does not protect the block here; lock bit is kept
          valid_ff[i] <= 1'b0;
          dirty_ff[i] <= 1'b0;
        end else if (clr_dirty_in && (mt_index_in == i)) begin
          // Valid stays set so the block remains usable
          dirty_ff[i] <= 1'b0;
        end else if (fill_en_in && (fill_index_in == i)) begin
          valid_ff[i] <= 1'b1;
          dirty_ff[i] <= fill_dirty_in;
          lock_ff[i]  <= fill_lock_in;
          tag_ff[i]   <= fill_tag_in;
        end
      end
    end
  endgenerate

endmodule

`default_nettype wire

// ### dcbm_top.v
// Notes on behaviour
// - Copy-back writes dirty valid block, clears dirty
// - Target block holds byte at base plus offset
// - Copied-back block stays valid in cache
// - Stall until the copy-back write finishes
// - Clean or absent copy-back: no change, no stall
// - Uncached aperture addresses are left untouched
// - Replacement state never altered by maintenance
// - Cancel prefetches, drain non-empty copy-back buffers
// - Guard bit zero means nothing happens, no stall
// - Invalidate clears valid and dirty, no write
// - Invalidate also clears locked blocks
// - Invalidate stalls as needed; absent block untouched
`default_nettype none
`include "dcbm_regs.vh"

module dcbm_top (
  input  wire                     sys_clk_in,
  input  wire                     rst_n_in,
  // Operation issue from the pipeline
  input  wire                     op_valid_in,
  input  wire                     op_kind_in,
  input  wire                     op_guard_present_in,
  input  wire [`DCBM_AW-1:0]      op_guard_in,
  input  wire [`DCBM_AW-1:0]      base_address_operand_in,
  input  wire [`DCBM_MOD_W-1:0]   op_mod_in,
  output wire                     op_ready_out,
  output wire                     op_done_out,
  output wire                     stall_out,
  // Cache fill port from the refill logic
  input  wire                     fill_en_in,
  input  wire [`DCBM_IDX_W-1:0]   fill_index_in,
  input  wire [`DCBM_TAG_W-1:0]   fill_tag_in,
  input  wire                     fill_dirty_in,
  input  wire                     fill_lock_in,
  // Block write to main memory
  output wire                     mem_wr_req_out,
  output wire [`DCBM_AW-1:0]      mem_wr_addr_out,
  input  wire                     mem_wr_ack_in,
  // Prefetch engine and copy-back buffers
  output wire                     pf_cancel_out,
  output wire                     cbb_drain_out,
  input  wire                     cbb_nonempty_in,
  // APB slave
  input  wire                     psel_in,
  input  wire                     penable_in,
  input  wire                     pwrite_in,
  input  wire [`DCBM_PADDR_W-1:0] paddr_in,
  input  wire [`DCBM_AW-1:0]      pwdata_in,
  output wire [`DCBM_AW-1:0]      prdata_out,
  output wire                     pready_out,
  output wire                     pslverr_out
);

  ////////////////////////////////////////////////////////////////////////////
  // State encoding

  localparam [1:0] ST_IDLE  = 2'h0;  // Waiting for an operation
  localparam [1:0] ST_WRITE = 2'h1;  // Block write to memory in flight
  localparam [1:0] ST_DRAIN = 2'h2;  // Waiting for copy-back buffers

  ////////////////////////////////////////////////////////////////////////////
  // Declarations

  reg  [1:0]              state_ff;       // Sequencer state
  reg  [1:0]              nxt_state;
  reg                     ready_ff;       // Free to accept an operation
  reg                     done_ff;        // One-cycle completion pulse
  reg                     stall_ff;       // Pipeline stall request
  reg                     wr_req_ff;      // Memory write request
  reg  [`DCBM_AW-1:0]     wr_addr_ff;     // Block-aligned write address
  reg  [`DCBM_IDX_W-1:0]  mt_index_ff;    // Set under maintenance
  reg                     pf_cancel_ff;   // One-cycle prefetch cancel
  reg                     drain_ff;       // Drain request to buffers
  reg                     locked_ff;      // Last invalidated block was locked
  reg                     enable_ff;      // Control: unit enabled
  reg  [`DCBM_AW-1:0]     nc_base_ff;     // Uncached window base
  reg  [`DCBM_AW-1:0]     nc_limit_ff;    // Uncached window limit
  reg  [15:0]             cb_cnt_ff;      // Copy-backs performed
  reg  [15:0]             inv_cnt_ff;     // Invalidates performed
  reg  [`DCBM_AW-1:0]     prdata_ff;      // APB read data
  reg                     pready_ff;      // APB ready
  reg                     pslverr_ff;     // APB error
  reg  [`DCBM_AW-1:0]     nxt_rdata;
  reg                     nxt_err;

  wire [`DCBM_AW-1:0]     tgt_addr;       // Byte address of target
  wire [`DCBM_IDX_W-1:0]  tgt_index;
  wire [`DCBM_TAG_W-1:0]  tgt_tag;
  wire                    cacheable;
  wire                    hit;
  wire                    dirty;
  wire                    locked;
  wire                    accept;         // Operation taken this cycle
  wire                    guard_ok;
  wire                    perform;        // Operation actually carried out
  wire                    do_cb;          // Copy-back needs a memory write
  wire                    do_inv;         // Invalidate hits a block
  wire                    clr_dirty;
  wire                    apb_wr;
  wire                    apb_rd_setup;

  ////////////////////////////////////////////////////////////////////////////
  // Address generation and tag state

  dcbm_addr_calc u_addr (
    .base_address_operand_in (base_address_operand_in),
    .mod_in                  (op_mod_in),
    .nc_base_in              (nc_base_ff),
    .nc_limit_in             (nc_limit_ff),
    .addr_out                (tgt_addr),
    .index_out               (tgt_index),
    .tag_out                 (tgt_tag),
    .cacheable_out           (cacheable)
  );

  // The store holds no age state, so maintenance cannot disturb replacement
  dcbm_tag_store u_tags (
    .sys_clk_in    (sys_clk_in),
    .rst_n_in      (rst_n_in),
    .lk_index_in   (tgt_index),
    .lk_tag_in     (tgt_tag),
    .lk_hit_out    (hit),
    .lk_dirty_out  (dirty),
    .lk_locked_out (locked),
    .fill_en_in    (fill_en_in),
    .fill_index_in (fill_index_in),
    .fill_tag_in   (fill_tag_in),
    .fill_dirty_in (fill_dirty_in),
    .fill_lock_in  (fill_lock_in),
    .clr_dirty_in  (clr_dirty),
    .inval_in      (do_inv),
    .mt_index_in   (do_inv ? tgt_index : mt_index_ff)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Operation decode

  // Only one operation in flight; others wait on op_ready_out
  assign accept   = op_valid_in && ready_ff;
  // Guard absent, or guard LSB set
  assign guard_ok = ~op_guard_present_in | op_guard_in[0];
  assign perform  = accept && guard_ok && enable_ff && cacheable;

  // Copy-back writes only when valid and dirty; otherwise no write and no stall
  assign do_cb  = perform && (op_kind_in == `DCBM_OP_COPYBACK) &&
                  hit && dirty;
  // Invalidate of a missing block changes nothing
  assign do_inv = perform && (op_kind_in == `DCBM_OP_INVALIDATE) &&
                  hit;

  // Dirty is cleared only once memory has taken the block
  assign clr_dirty = (state_ff == ST_WRITE) && mem_wr_ack_in;

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer next state

  always @* begin
    nxt_state = state_ff;
    case (state_ff)
      ST_IDLE: begin
        if (do_cb) begin
          nxt_state = ST_WRITE;
        end else if (do_inv) begin
          nxt_state = ST_DRAIN;
        end
      end
      ST_WRITE: begin
        // Hold until memory acknowledges the block write
        if (mem_wr_ack_in) begin
          nxt_state = ST_DRAIN;
        end
      end
      ST_DRAIN: begin
        if (!cbb_nonempty_in) begin
          nxt_state = ST_IDLE;
        end
      end
      default: begin
        nxt_state = ST_IDLE;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer registers and pipeline handshake

  always @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      state_ff    <= ST_IDLE;
      ready_ff    <= 1'b1;
      done_ff     <= 1'b0;
      stall_ff    <= 1'b0;
      mt_index_ff <= {`DCBM_IDX_W{1'b0}};
      locked_ff   <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      // Stall exactly while the operation is busy; none for no-ops
      stall_ff <= (nxt_state != ST_IDLE);
      ready_ff <= (nxt_state == ST_IDLE);
      // Done fires for no-op accepts too, so the issuer can retire them
      done_ff  <= (accept && !do_cb && !do_inv) ||
                  ((state_ff != ST_IDLE) && (nxt_state == ST_IDLE));
      if (accept) begin
        mt_index_ff <= tgt_index;
      end
      if (do_inv) begin
        locked_ff <= locked;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Memory write of the target block

  always @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      wr_req_ff  <= 1'b0;
      wr_addr_ff <= `DCBM_ZERO32;
    end else if (do_cb) begin
      // Request held stable until acknowledged
      wr_req_ff  <= 1'b1;
      wr_addr_ff <= {tgt_addr[`DCBM_AW-1:`DCBM_OFS_W],
                     {`DCBM_OFS_W{1'b0}}};
    end else if (clr_dirty) begin
      wr_req_ff  <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Prefetch cancel and buffer drain

  // Every performed operation flushes, even one that finds no block
  // A busy op keeps asking: buffers may refill while it waits, and the
  // drain state would otherwise wait forever for them to empty
  always @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      pf_cancel_ff <= 1'b0;
      drain_ff     <= 1'b0;
    end else begin
      pf_cancel_ff <= perform;
      if ((perform || (state_ff != ST_IDLE)) && cbb_nonempty_in) begin
        drain_ff <= 1'b1;
      end else if (!cbb_nonempty_in) begin
        drain_ff <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Operation counters

  always @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      cb_cnt_ff  <= 16'h0000;
      inv_cnt_ff <= 16'h0000;
    end else begin
      if (clr_dirty) begin
        cb_cnt_ff <= cb_cnt_ff + `DCBM_ONE16;
      end
      if (do_inv) begin
        inv_cnt_ff <= inv_cnt_ff + `DCBM_ONE16;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // APB slave: zero wait states, ready asserted in every access phase

  assign apb_rd_setup = psel_in && !penable_in;
  // Write lands at the edge that completes the access phase
  assign apb_wr = psel_in && penable_in && pready_ff && pwrite_in;

  // Register writes
  always @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      enable_ff   <= `DCBM_CTRL_RST;
      nc_base_ff  <= `DCBM_NC_BASE_RST;
      nc_limit_ff <= `DCBM_NC_LIMIT_RST;
    end else if (apb_wr) begin
      case (paddr_in)
        `DCBM_REG_CTRL: begin
          enable_ff <= pwdata_in[0];
        end
        `DCBM_REG_NC_BASE: begin
          nc_base_ff <= pwdata_in;
        end
        `DCBM_REG_NC_LIMIT: begin
          nc_limit_ff <= pwdata_in;
        end
        default: begin
          enable_ff <= enable_ff;
        end
      endcase
    end
  end

  // Read mux and address check, evaluated in the setup cycle
  always @* begin
    nxt_rdata = `DCBM_ZERO32;
    nxt_err   = 1'b0;
    case (paddr_in)
      `DCBM_REG_CTRL: begin
        nxt_rdata[0] = enable_ff;
      end
      `DCBM_REG_NC_BASE: begin
        nxt_rdata = nc_base_ff;
      end
      `DCBM_REG_NC_LIMIT: begin
        nxt_rdata = nc_limit_ff;
      end
      `DCBM_REG_STATUS: begin
        nxt_rdata[`DCBM_ST_BUSY]   = stall_ff;
        nxt_rdata[`DCBM_ST_DRAIN]  = drain_ff;
        nxt_rdata[`DCBM_ST_WRITE]  = wr_req_ff;
        nxt_rdata[`DCBM_ST_LOCKED] = locked_ff;
      end
      `DCBM_REG_CB_CNT: begin
        nxt_rdata[15:0] = cb_cnt_ff;
      end
      `DCBM_REG_INV_CNT: begin
        nxt_rdata[15:0] = inv_cnt_ff;
      end
      default: begin
        // Unmapped: error, reads zero, writes dropped
        nxt_err = 1'b1;
      end
    endcase
  end

  // Answer registered at the end of the setup cycle
  always @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff  <= `DCBM_ZERO32;
    end else begin
      pready_ff  <= apb_rd_setup;
      pslverr_ff <= apb_rd_setup && nxt_err;
      if (apb_rd_setup && !pwrite_in) begin
        prdata_ff <= nxt_rdata;
      end else begin
        prdata_ff <= `DCBM_ZERO32;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs, all straight from flip-flops

  assign op_ready_out    = ready_ff;
  assign op_done_out     = done_ff;
  assign stall_out       = stall_ff;
  assign mem_wr_req_out  = wr_req_ff;
  assign mem_wr_addr_out = wr_addr_ff;
  assign pf_cancel_out   = pf_cancel_ff;
  assign cbb_drain_out   = drain_ff;
  assign prdata_out      = prdata_ff;
  assign pready_out      = pready_ff;
  assign pslverr_out     = pslverr_ff;

endmodule

`default_nettype wire

// ### dcbm_checker.sv
`default_nettype none
`include "dcbm_regs.vh"
// Watches the maintenance port and the memory and drain handshakes
module dcbm_checker (
  input wire logic                sys_clk_in,
  input wire logic                rst_n_in,
  input wire logic                op_valid_in,
  input wire logic                op_kind_in,
  input wire logic                op_guard_present_in,
  input wire logic [`DCBM_AW-1:0] op_guard_in,
  input wire logic                op_ready_out,
  input wire logic                op_done_out,
  input wire logic                stall_out,
  input wire logic                mem_wr_req_out,
  input wire logic [`DCBM_AW-1:0] mem_wr_addr_out,
  input wire logic                mem_wr_ack_in,
  input wire logic                pf_cancel_out,
  input wire logic                cbb_nonempty_in
);
  timeunit 1ns;
  timeprecision 1ps;
  logic inv_busy_ff; // Invalidate in flight
  //////////////////////////////////////////////////////////////////////
  // Kind of the op in flight; a new accept wins over a retire pulse
  always @(posedge sys_clk_in) begin
    if (!rst_n_in)
      inv_busy_ff <= 1'b0;
    else if (op_valid_in && op_ready_out)
      inv_busy_ff <= op_kind_in == `DCBM_OP_INVALIDATE;
    else if (op_done_out)
      inv_busy_ff <= 1'b0;
  end
  //////////////////////////////////////////////////////////////////////
  default clocking dflt @(posedge sys_clk_in); endclocking
  default disable iff (!rst_n_in);
  guard_noop_a: assert property (
    op_valid_in && op_ready_out && op_guard_present_in && !op_guard_in[0]
    |=> op_done_out && !stall_out && !mem_wr_req_out)
    else $error("guarded-off op did work");
  busy_refuse_a: assert property (stall_out |-> !op_ready_out)
    else $error("ready while stalled");
  wr_hold_a: assert property (
    mem_wr_req_out && !mem_wr_ack_in
    |=> mem_wr_req_out && $stable(mem_wr_addr_out))
    else $error("write request dropped or moved");
  wr_align_a: assert property (
    mem_wr_req_out |-> mem_wr_addr_out[4:0] == 5'h00 && stall_out)
    else $error("write not block aligned or not stalled");
  inval_nowr_a: assert property (inv_busy_ff |-> !mem_wr_req_out)
    else $error("invalidate wrote memory");
  cancel_cause_a: assert property (
    pf_cancel_out |-> $past(op_valid_in && op_ready_out))
    else $error("prefetch cancel without accept");
  drain_done_a: assert property (
    $fell(stall_out) |-> op_done_out && !$past(cbb_nonempty_in))
    else $error("stall ended before drain");
  ack_release_a: assert property (
    mem_wr_req_out && mem_wr_ack_in |=> !mem_wr_req_out)
    else $error("write held after ack");
  stall_bound_a: assert property (
    $rose(stall_out) |-> ##[1:100] !stall_out)
    else $error("stall never ended");
endmodule
bind dcbm_top dcbm_checker u_chk (.sys_clk_in, .rst_n_in, .op_valid_in,
  .op_kind_in, .op_guard_present_in, .op_guard_in, .op_ready_out,
  .op_done_out, .stall_out, .mem_wr_req_out, .mem_wr_addr_out,
  .mem_wr_ack_in, .pf_cancel_out, .cbb_nonempty_in);
`default_nettype wire

// ### dcbm_mem_model.sv
`default_nettype none
// Main memory write port and copy-back buffers behind the block
module dcbm_mem_model (
  input  wire logic sys_clk_in,
  input  wire logic rst_n_in,
  input  wire logic wr_req_in,
  input  wire logic drain_in,
  input  wire logic slow_in,
  input  wire logic load_in,
  output wire logic wr_ack_out,
  output wire logic nonempty_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic       ack_ff;  // One-cycle acknowledge
  logic [2:0] wait_ff; // Cycles left before acknowledge
  logic [1:0] cnt_ff;  // Words held in the buffers
  //////////////////////////////////////////////////////////////////////
  // One acknowledge per request, prompt or after a slow wait
  always @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      ack_ff <= 1'b0;
      wait_ff <= 3'h0;
    end else if (ack_ff) begin
      ack_ff <= 1'b0;
    end else if (wr_req_in && wait_ff == 3'h0) begin
      ack_ff <= 1'b1;
    end else if (wr_req_in) begin
      wait_ff <= wait_ff - 3'h1;
    end else begin
      wait_ff <= slow_in ? 3'h5 : 3'h0;
    end
  end
  // Buffers empty only while the block asks for a drain
  always @(posedge sys_clk_in) begin
    if (!rst_n_in)
      cnt_ff <= 2'h0;
    else if (load_in)
      cnt_ff <= 2'h3;
    else if (drain_in && cnt_ff != 2'h0)
      cnt_ff <= cnt_ff - 2'h1;
  end
  assign wr_ack_out = ack_ff;
  assign nonempty_out = cnt_ff != 2'h0;
endmodule
`default_nettype wire

// ### dcbm_tb.sv
`default_nettype none
`include "dcbm_regs.vh"
`define CHK(g, e) begin \
  compares++; \
  if ((g) !== (e)) begin \
    n_errors++; \
    $display("unexpected at %0t: got %h exp %h", $time, g, e); \
  end \
end
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk_in, rst_n_in, op_valid_in, op_kind_in, op_guard_present_in;
  logic op_ready_out, op_done_out, stall_out, fill_en_in, fill_dirty_in;
  logic fill_lock_in, mem_wr_req_out, mem_wr_ack_in, pf_cancel_out;
  logic cbb_drain_out, cbb_nonempty_in, psel_in, penable_in, pwrite_in;
  logic pready_out, pslverr_out, slow, load, err, saw_st, saw_wr;
  logic [31:0] op_guard_in, base_address_operand_in, mem_wr_addr_out;
  logic [31:0] pwdata_in, prdata_out, rd, saw_a, a, ncb, ncl;
  logic [6:0]  op_mod_in;
  logic [3:0]  fill_index_in;
  logic [22:0] fill_tag_in, tg [16];
  logic [11:0] paddr_in;
  logic        vld [16], dty [16];
  logic [33:0] q [$], ex;  // Expected stall, write and write address
  logic [32:0] rv [7] = '{33'h1, 33'h0ffff_ffff, 33'h0, 33'h0, 33'h0,
                          33'h0, 33'h1_0000_0000};
  int          n_errors = 0, compares = 0, n_pf = 0, exp_pf = 0;
  dcbm_top dut (.*);
  dcbm_mem_model u_mem (.sys_clk_in, .rst_n_in, .wr_req_in(mem_wr_req_out),
    .drain_in(cbb_drain_out), .slow_in(slow), .load_in(load),
    .wr_ack_out(mem_wr_ack_in), .nonempty_out(cbb_nonempty_in));
  always #12.5 sys_clk_in = ~sys_clk_in;
  //////////////////////////////////////////////////////////////////////
  task automatic conclude();
    if (n_errors == 0 && compares > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // One APB transfer; the request holds until pready is sampled
  task automatic apb(input logic w, input logic [11:0] ad,
                     input logic [31:0] d);
    @(posedge sys_clk_in);
    psel_in <= 1'b1;
    pwrite_in <= w;
    paddr_in <= ad;
    pwdata_in <= d;
    @(posedge sys_clk_in);
    penable_in <= 1'b1;
    do @(posedge sys_clk_in); while (pready_out !== 1'b1);
    rd = prdata_out;
    err = pslverr_out;
    psel_in <= 1'b0;
    penable_in <= 1'b0;
  endtask
  // Fill only while idle, so no op races the fill on one set
  task automatic fill(input logic [31:0] t, input logic d, input logic l);
    do @(posedge sys_clk_in); while (op_ready_out !== 1'b1);
    fill_en_in <= 1'b1;
    fill_index_in <= t[8:5];
    fill_tag_in <= t[31:9];
    fill_dirty_in <= d;
    fill_lock_in <= l;
    @(posedge sys_clk_in);
    fill_en_in <= 1'b0;
    vld[t[8:5]] = 1'b1;
    tg[t[8:5]] = t[31:9];
    dty[t[8:5]] = d;
  endtask
  // Issue one op at target t and note what it should do
  task automatic op(input logic k, input logic gp, input logic g0,
                    input logic [31:0] t, input logic [6:0] m);
    logic [3:0] i;
    logic       pf;
    logic       h;
    i = t[8:5];
    pf = (!gp || g0) && !(t >= ncb && t <= ncl);
    h = pf && vld[i] && tg[i] == t[31:9];
    @(posedge sys_clk_in);
    op_valid_in <= 1'b1;
    op_kind_in <= k;
    op_guard_present_in <= gp;
    op_guard_in <= {31'($urandom), g0};
    base_address_operand_in <= t - {{23{m[6]}}, m, 2'b00};
    op_mod_in <= m;
    do @(posedge sys_clk_in); while (op_ready_out !== 1'b1);
    op_valid_in <= 1'b0;
    exp_pf += int'(pf);
    if (k == `DCBM_OP_COPYBACK) begin
      q.push_back({{2{h && dty[i]}}, h && dty[i] ? {t[31:5], 5'h0} : 32'h0});
      dty[i] = dty[i] && !h;
    end else begin
      q.push_back({h, 1'b0, 32'h0});
      vld[i] = vld[i] && !h;
      dty[i] = dty[i] && !h;
    end
  endtask
  //////////////////////////////////////////////////////////////////////
  // Gather what each op did and compare on its retire pulse
  always @(posedge sys_clk_in) begin
    if (pf_cancel_out === 1'b1)
      n_pf++;
    if (op_done_out === 1'b1) begin
      ex = q.pop_front();
      `CHK({saw_st, saw_wr, saw_a}, ex)
      saw_st = 1'b0;
      saw_wr = 1'b0;
      saw_a = 32'h0;
    end else begin
      saw_st = saw_st | (stall_out === 1'b1);
      if (mem_wr_req_out === 1'b1) begin
        saw_wr = 1'b1;
        saw_a = mem_wr_addr_out;
      end
    end
  end
  // Watchdog; the whole run needs well under this span
  initial begin
    #300us;
    n_errors++;
    conclude();
  end
  //////////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(81));
    {sys_clk_in, rst_n_in, op_valid_in, op_kind_in, op_guard_present_in,
     fill_en_in, fill_dirty_in, fill_lock_in, psel_in, penable_in,
     pwrite_in, slow, load, saw_st, saw_wr} = '0;
    {op_guard_in, base_address_operand_in, pwdata_in, saw_a} = '0;
    {op_mod_in, fill_index_in, fill_tag_in, paddr_in} = '0;
    ncb = 32'hffff_ffff;
    ncl = 32'h0;
    for (int s = 0; s < 16; s++)
      {vld[s], dty[s], tg[s]} = '0;
    repeat (16) @(posedge sys_clk_in);
    rst_n_in <= 1'b1;
    for (int k = 0; k < 7; k++) begin
      apb(1'b0, 12'(k * 4), 32'h0);
      `CHK({err, rd}, rv[k])
    end
    fill(32'h0001_2360, 1'b1, 1'b0);
    op(`DCBM_OP_COPYBACK, 1'b1, 1'b0, 32'h0001_2360, 7'h05);
    op(`DCBM_OP_INVALIDATE, 1'b1, 1'b0, 32'h0001_2360, 7'h06);
    op(`DCBM_OP_COPYBACK, 1'b1, 1'b1, 32'h0001_2361, 7'h40);
    op(`DCBM_OP_COPYBACK, 1'b0, 1'b0, 32'h0001_237f, 7'h3f);
    op(`DCBM_OP_INVALIDATE, 1'b0, 1'b0, 32'h0001_2360, 7'h00);
    op(`DCBM_OP_COPYBACK, 1'b0, 1'b0, 32'h0001_2360, 7'h01);
    fill(32'h0abc_d4a0, 1'b1, 1'b1);
    op(`DCBM_OP_INVALIDATE, 1'b1, 1'b1, 32'h0abc_d4a4, 7'h7f);
    op(`DCBM_OP_COPYBACK, 1'b0, 1'b0, 32'h0abc_d4a0, 7'h10);
    apb(1'b1, `DCBM_REG_NC_BASE, 32'h4000);
    apb(1'b1, `DCBM_REG_NC_LIMIT, 32'h7fff);
    {ncb, ncl} = {32'h4000, 32'h7fff};
    fill(32'h0000_4020, 1'b1, 1'b0);
    op(`DCBM_OP_COPYBACK, 1'b0, 1'b0, 32'h0000_4020, 7'h02);
    op(`DCBM_OP_INVALIDATE, 1'b0, 1'b0, 32'h0000_4020, 7'h03);
    apb(1'b1, `DCBM_REG_NC_BASE, 32'hffff_ffff);
    apb(1'b1, `DCBM_REG_NC_LIMIT, 32'h0);
    {ncb, ncl} = {32'hffff_ffff, 32'h0};
    op(`DCBM_OP_COPYBACK, 1'b0, 1'b0, 32'h0000_4020, 7'h44);
    // Random traffic over few tags, so hits, misses and reuse all occur
    for (int n = 0; n < 80; n++) begin
      a = {21'h0, 2'($urandom), 4'($urandom), 5'($urandom)};
      if ($urandom % 2)
        fill(a, 1'($urandom), 1'($urandom));
      @(posedge sys_clk_in);
      slow <= 1'($urandom);
      load <= 1'($urandom);
      @(posedge sys_clk_in);
      load <= 1'b0;
      op(1'($urandom), 1'($urandom), 1'($urandom), a, 7'($urandom));
    end
    while (q.size() != 0)
      @(posedge sys_clk_in);
    `CHK(n_pf, exp_pf)
    conclude();
  end
endmodule
`default_nettype wire
